// file: hw/ssy_pkg.sv
// Package for the slave-select synchronous serial port
package ssy_pkg;
	localparam logic [3:0] SSY_MODE_SEL_ON = 4'h4;
	localparam logic [3:0] SSY_MODE_SEL_OFF = 4'h5;
	localparam int SSY_BITS = 8;
	localparam logic [2:0] SSY_CNT_RESET = 3'h0;
	localparam logic [7:0] SSY_BYTE_RESET = 8'h00;
	localparam int SSY_FIFO_DEPTH = 32;
	localparam int SSY_SYNC_STAGES = 2;

	typedef struct packed {
		logic       port_enable_bit;
		logic [3:0] mode;
		logic       clock_edge_select;
		logic       idle_high;
		logic       data_out_is_input;
		logic       wake_enable;
	} ssy_cfg_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ssy_byte_type;
endpackage

// file: hw/ssy_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
`default_nettype none
module ssy_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// file: hw/ssy_slave.sv
// Serial slave with slave-select synchronisation and receive FIFO
`timescale 1ns/1ns
`default_nettype none
module ssy_slave #(
	parameter int DEPTH = ssy_pkg::SSY_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst,
	// Configuration
	input  wire ssy_pkg::ssy_cfg_type cfg,
	input  wire logic               sleeping,
	// Serial pins
	input  wire logic               serial_clock_pin,
	input  wire logic               slave_select_pin_n,
	input  wire logic               serial_data_in_pin,
	output logic                    serial_data_out_pin,
	output logic                    serial_data_out_pin_oe,
	// Transmit byte load
	input  wire logic [7:0]         tx_data,
	input  wire logic               tx_load,
	// Flags
	output logic                    port_transfer_flag,
	input  wire logic               flag_clear,
	output logic                    wake_request,
	output logic                    overflow,
	// Receive stream
	output ssy_pkg::ssy_byte_type   rx_out,
	input  wire logic               rx_ready
);
	import ssy_pkg::*;

	logic [1:0] sck_sync;
	logic [1:0] ss_sync;
	logic [1:0] sdi_sync;
	logic       sck_prev;
	logic       sck_rise;
	logic       sck_fall;
	logic       sel_mode;
	logic       sel_active;
	logic       module_reset;
	logic       xfer_en;
	logic       sample_edge;
	logic       shift_edge;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic       byte_done;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic [7:0] fifo_out_data;

	// Pin synchronisers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sck_sync <= '0;
			ss_sync <= 2'h3;
			sdi_sync <= '0;
		end else begin
			sck_sync <= {sck_sync[0], serial_clock_pin};
			ss_sync <= {ss_sync[0], slave_select_pin_n};
			sdi_sync <= {sdi_sync[0], serial_data_in_pin};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sck_prev <= 1'b0;
		end else begin
			sck_prev <= sck_sync[1];
		end
	end

	assign sck_rise = sck_sync[1] && !sck_prev;
	assign sck_fall = !sck_sync[1] && sck_prev;
	assign sel_mode = cfg.port_enable_bit && (cfg.mode == SSY_MODE_SEL_ON);
	assign sel_active = !sel_mode || !ss_sync[1];
	// reset on select high in select mode, or on disable
	assign module_reset = !cfg.port_enable_bit || (sel_mode && ss_sync[1]);
	assign xfer_en = cfg.port_enable_bit && sel_active;
	// Capture edge depends on idle level and edge select
	assign sample_edge = (cfg.clock_edge_select ^ cfg.idle_high) ? sck_rise : sck_fall;
	assign shift_edge = (cfg.clock_edge_select ^ cfg.idle_high) ? sck_fall : sck_rise;
	assign byte_done = xfer_en && sample_edge && (bit_cnt == 3'h7);
	assign next_shreg = {shreg[6:0], sdi_sync[1]};

	always_ff @(posedge clk_sys) begin
		if (rst || module_reset) begin
			bit_cnt <= SSY_CNT_RESET;
		end else if (xfer_en && sample_edge) begin
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shreg <= SSY_BYTE_RESET;
		end else if (tx_load && (module_reset || bit_cnt == SSY_CNT_RESET) && !sample_edge) begin
			shreg <= tx_data;
		end else if (xfer_en && sample_edge) begin
			shreg <= next_shreg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			serial_data_out_pin <= 1'b0;
			serial_data_out_pin_oe <= 1'b0;
		end else begin
			serial_data_out_pin_oe <= xfer_en && !cfg.data_out_is_input;
			if (xfer_en && (shift_edge || bit_cnt == SSY_CNT_RESET)) begin
				serial_data_out_pin <= shreg[7];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			port_transfer_flag <= 1'b0;
		end else if (byte_done) begin
			port_transfer_flag <= 1'b1;
		end else if (flag_clear) begin
			port_transfer_flag <= 1'b0;
		end
	end

	// wake from sleep on received byte
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= byte_done && sleeping && cfg.wake_enable;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			overflow <= 1'b0;
		end else if (byte_done && !fifo_in_ready) begin
			overflow <= 1'b1;
		end else if (flag_clear) begin
			overflow <= 1'b0;
		end
	end

	ssy_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (byte_done),
		.in_ready  (fifo_in_ready),
		.in_data   (next_shreg),
		.out_valid (fifo_out_valid),
		.out_ready (rx_ready && !rx_out.valid),
		.out_data  (fifo_out_data)
	);

	// Registered output stage
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_out <= '0;
		end else if (fifo_out_valid && !rx_out.valid && rx_ready) begin
			rx_out <= '{valid: 1'b1, data: fifo_out_data};
		end else begin
			rx_out.valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: verif/ssy_slave_sva.sv
// Checker for the serial slave port
`timescale 1ns/1ns
`default_nettype none
module ssy_slave_sva (
	// Clock and inputs
	input wire logic                  clk_sys,
	input wire logic                  rst,
	input wire ssy_pkg::ssy_cfg_type  cfg,
	input wire logic                  sleeping,
	input wire logic                  slave_select_pin_n,
	input wire logic                  flag_clear,
	input wire logic                  rx_ready,
	// Outputs
	input wire logic                  serial_data_out_pin_oe,
	input wire logic                  port_transfer_flag,
	input wire logic                  wake_request,
	input wire ssy_pkg::ssy_byte_type rx_out
);
	import ssy_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire sel = cfg.port_enable_bit && cfg.mode == SSY_MODE_SEL_ON;
	wire oe = serial_data_out_pin_oe;
	a_oe_deselect: assert property ((sel && slave_select_pin_n)[*5] |-> !oe)
		else $error("oe while deselected");
	a_oe_select: assert property ((sel && !slave_select_pin_n && !cfg.data_out_is_input)[*6] |-> oe)
		else $error("oe low while selected");
	a_oe_input: assert property (cfg.data_out_is_input[*2] |-> !oe)
		else $error("oe while input");
	a_oe_disabled: assert property ((!cfg.port_enable_bit)[*2] |-> !oe)
		else $error("oe while disabled");
	a_flag_holds: assert property (port_transfer_flag && !flag_clear |=> port_transfer_flag)
		else $error("flag lost");
	a_flag_cleared: assert property ($fell(port_transfer_flag) |-> $past(flag_clear))
		else $error("flag fell uncleared");
	a_wake_cause: assert property (wake_request |-> $past(sleeping) && $past(cfg.wake_enable))
		else $error("wake without cause");
	a_rx_follows: assert property ($rose(port_transfer_flag) && rx_ready && !rx_out.valid |=> rx_out.valid)
		else $error("byte not delivered");
endmodule
bind ssy_slave ssy_slave_sva chk_u (.clk_sys, .rst, .cfg, .sleeping, .slave_select_pin_n,
	.flag_clear, .rx_ready, .serial_data_out_pin_oe, .port_transfer_flag, .wake_request, .rx_out);
`default_nettype wire

// file: verif/ssy_master_model.sv
// Behavioural SPI master driving clock, select and data
`timescale 1ns/1ns
`default_nettype none
module ssy_master_model (
	// Serial pins
	output logic      serial_clock_pin,
	output logic      slave_select_pin_n,
	output logic      serial_data_in_pin,
	input  wire logic serial_data_out_pin
);
	initial begin
		serial_clock_pin = 1'b0;
		slave_select_pin_n = 1'b1;
		serial_data_in_pin = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		slave_select_pin_n = 1'b0;
		#400;
		for (int i = 7; i >= 8 - n; i--) begin
			serial_data_in_pin = tx[i];
			#200 serial_clock_pin = 1'b1;
			#150 rx[i] = serial_data_out_pin;
			#50 serial_clock_pin = 1'b0;
		end
		#400 slave_select_pin_n = 1'b1;
		serial_data_in_pin = ~serial_data_in_pin;
		#400;
	endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the serial slave port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ssy_pkg::*;
	logic clk_sys = 1'b0, rst = 1'b1, sleeping = 1'b0, tx_load = 1'b0, flag_clear = 1'b0;
	logic rx_ready = 1'b1, sdo, oe, flag, wake, ovf, woke, tog = 1'b0;
	logic [7:0] tx_data = 8'h00, q[$];
	logic [31:0] seed = 32'h0001476e;
	int fail_count = 0, samples_checked = 0, cyc = 0;
	ssy_cfg_type cfg = '0;
	ssy_byte_type rx_out;
	wire serial_clock_pin, slave_select_pin_n, serial_data_in_pin;
	// Released line shows a changing pattern
	wire serial_data_out_pin = oe ? sdo : tog;
	ssy_slave dut_u (.clk_sys, .rst, .cfg, .sleeping, .serial_clock_pin, .slave_select_pin_n,
		.serial_data_in_pin, .serial_data_out_pin(sdo), .serial_data_out_pin_oe(oe), .tx_data,
		.tx_load, .port_transfer_flag(flag), .flag_clear, .wake_request(wake), .overflow(ovf),
		.rx_out, .rx_ready);
	ssy_master_model m_u (.serial_clock_pin, .slave_select_pin_n, .serial_data_in_pin,
		.serial_data_out_pin);
	always #25 clk_sys = ~clk_sys;
	task automatic end_of_test();
		$display("checks %0d fails %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	always @(posedge clk_sys) begin
		tog <= ~tog;
		cyc <= cyc + 1;
		if (wake === 1'b1) woke <= 1'b1;
		if (rx_out.valid === 1'b1) chk(rx_out.data, q.pop_front());
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic xb(input logic [7:0] mo, so, input int n, input logic push, ev);
		logic [7:0] got;
		logic ew;
		ew = sleeping && cfg.wake_enable;
		@(posedge clk_sys) #1;
		woke = 1'b0;
		tx_data = so;
		tx_load = 1'b1;
		@(posedge clk_sys) #1;
		tx_load = 1'b0;
		if (push) q.push_back(mo);
		m_u.xfer(mo, n, got);
		if (n == 8) begin
			if (!cfg.data_out_is_input) chk(got, so);
			chk({5'h00, woke, ovf, flag}, {5'h00, ew, ev, 1'b1});
			@(posedge clk_sys) #1;
			flag_clear = 1'b1;
			@(posedge clk_sys) #1;
			flag_clear = 1'b0;
		end
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		#1 rst = 1'b0;
		cfg = '{1'b1, SSY_MODE_SEL_ON, 1'b1, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			sleeping = i[0];
			xb(seed[7:0], seed[15:8], 8, 1'b1, 1'b0);
		end
		$display("test random done");
		for (int k = 0; k < 2; k++) begin
			cfg.mode = k ? SSY_MODE_SEL_OFF : SSY_MODE_SEL_ON;
			xb(8'hff, 8'h00, 4, 1'b0, 1'b0);
			cfg.port_enable_bit = k[0] ? 1'b0 : 1'b1;
			repeat (4) @(posedge clk_sys);
			#1 cfg.port_enable_bit = 1'b1;
			xb(8'ha5, 8'h3c, 8, 1'b1, 1'b0);
		end
		cfg.data_out_is_input = 1'b1;
		xb(8'h81, 8'h7e, 8, 1'b1, 1'b0);
		cfg.data_out_is_input = 1'b0;
		$display("test abort done");
		cfg.mode = SSY_MODE_SEL_ON;
		rx_ready = 1'b0;
		for (int i = 0; i < 33; i++) begin
			seed = xs(seed);
			xb(seed[7:0], 8'h00, 8, i < 32, i == 32);
		end
		rx_ready = 1'b1;
		// Drain takes two cycles per byte
		repeat (100) @(posedge clk_sys);
		chk(8'(q.size()), 8'h00);
		$display("test fifo done");
		end_of_test();
	end
endmodule
`default_nettype wire
